//--- hdl/msvg_defs.svh
// Purpose: Offsets, field positions, reset values and fixed counts of the generator.
// Assumes: Register index times four is the APB byte address.
// Notes:   Included by the package and the top module.
`ifndef MSVG_DEFS_SVH
`define MSVG_DEFS_SVH
`define MSVG_IX_PRESC     8'h38
`define MSVG_IX_PER_H     8'h39
`define MSVG_IX_PER_L     8'h3A
`define MSVG_IX_SCALE     8'h93
`define MSVG_IX_CEIL      8'hC8
`define MSVG_IX_KP        8'hE5
`define MSVG_IX_KI        8'hE6
`define MSVG_IX_KD        8'hE7
`define MSVG_IX_CTRL      8'hF0
`define MSVG_IX_MIN       8'hF1
`define MSVG_IX_DEAD      8'hF2
`define MSVG_IX_TGT_H     8'hF3
`define MSVG_IX_TGT_L     8'hF4
`define MSVG_IX_RAMP_NUM  8'hF5
`define MSVG_IX_SLOPE     8'hF6
`define MSVG_IX_AMP       8'hF7
`define MSVG_IX_ANGLE     8'hF8
`define MSVG_CTRL_SPD     0
`define MSVG_CTRL_AMP     1
`define MSVG_CTRL_RAMP    2
`define MSVG_CTRL_AUTO    3
`define MSVG_PRESC_SIGN   4
`define MSVG_RST_BYTE     8'h00
`define MSVG_PWM_MAX      9'h166
`define MSVG_TAB_MID      9'h0B3
`define MSVG_TAB_LEN      9'h100
`define MSVG_PRESC_LIM    15
`endif

//--- hdl/msvg_pkg.sv
// Purpose: Types shared by the phase voltage generator.
// Assumes: Constants come from the defs header.
// Notes:   The whole state lives in one packed struct.
package msvg_pkg;
`include "msvg_defs.svh"
   // Sine table storage type.
   typedef logic [8:0] msvg_rom_t [256];
   // Complete register state of the block.
   typedef struct packed {
      logic               pready;   // APB answer.
      logic               pslverr;  // APB error answer.
      logic [31:0]        prdata;   // APB read data.
      logic [4:0]         presc;    // Sign and magnitude prescaler.
      logic [14:0]        cntmax;   // Period mantissa.
      logic [7:0]         scale;    // Voltage scaler.
      logic [7:0]         ceil;     // Amplitude ceiling.
      logic [3:0]         kp;       // Proportional shift.
      logic [3:0]         ki;       // Integral shift.
      logic [3:0]         kd;       // Derivative shift.
      logic [3:0]         ctrl;     // Control bits.
      logic [7:0]         minlim;   // Lower output limit.
      logic [7:0]         dead;     // Dead time in carrier steps.
      logic [15:0]        target;   // Target turn length in cycles.
      logic [7:0]         rampnum;  // Ticks between ramp steps.
      logic [3:0]         slope;    // Ramp slope exponent.
      logic [7:0]         amp;      // Voltage amplitude output.
      logic [15:0]        precnt;   // Prescaler divider.
      logic [16:0]        acc;      // Mantissa accumulator.
      logic [7:0]         angle;    // Table address.
      logic [23:0]        turncnt;  // Cycles of the running turn.
      logic signed [23:0] elast;    // Previous error.
      logic signed [31:0] esum;     // Error sum.
      logic [7:0]         rampcnt;  // Ramp tick counter.
      logic [8:0]         carrier;  // PWM carrier.
      logic               up;       // Carrier direction.
      logic [2:0]         hs;       // High side gates.
      logic [2:0]         ls;       // Low side gates.
      logic [2:0]         mtrig;    // Current measurement triggers.
      logic               dtrig;    // Current direction trigger.
      logic               tick;     // Time base overflow.
   } msvg_state_t;
endpackage : msvg_pkg

//--- hdl/msvg_top.sv
// Purpose: Three phase centre aligned PWM with sine table, time base and speed PID.
// Assumes: APB slave at 10 MHz clk_sys; block_en comes from on-chip logic.
// Notes:   Every output is a field of the registered state.
`timescale 1ns/1ns
`include "msvg_defs.svh"
module msvg_top
   import msvg_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic        block_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [9:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [2:0]       gate_high,
   output logic [2:0]       gate_low,
   output logic [2:0]       meas_trig,
   output logic             dir_trig,
   output logic             tb_tick,
   output logic [7:0]       amplitude
);

   // Sine around mid code, built once at elaboration with a rational approximation.
   // table contents
   function automatic msvg_rom_t build_rom();
      msvg_rom_t r;
      int        h;
      int        p;
      int        s;
      for (int a = 0; a < 256; a++) begin
         h = a % 128;
         p = h * (128 - h);
         s = (179 * 4 * p + (20480 - p) / 2) / (20480 - p);
         r[a] = (a < 128) ? 9'(179 + s) : 9'(179 - s);
      end
      return r;
   endfunction : build_rom

   // Sign and magnitude to plain integer.
   // sign magnitude decode
   function automatic int sm_to_int(input logic [4:0] v);
      return v[`MSVG_PRESC_SIGN] ? -int'(v[3:0]) : int'(v[3:0]);
   endfunction : sm_to_int

   // Integer back to sign and magnitude, saturated at the field range.
   function automatic logic [4:0] int_to_sm(input int v);
      int m;
      m = (v < 0) ? -v : v;
      if (m > `MSVG_PRESC_LIM) begin
         m = `MSVG_PRESC_LIM;
      end
      return {v < 0, 4'(m)};
   endfunction : int_to_sm

   // Scaled threshold of one phase for a table address.
   // scaling around mid
   function automatic logic [8:0] phase_thr(input logic [8:0] tv, input logic [7:0] sc);
      logic signed [18:0] d;
      d = (19'(signed'({1'b0, tv})) - 19'sd179) * signed'({11'h000, sc});
      return 9'((d >>> 8) + 19'sd179);
   endfunction : phase_thr

   // Clamp a signed control value into the 8-bit output range.
   function automatic logic [7:0] clamp8(input logic signed [33:0] v,
                                         input logic [7:0] lo, input logic [7:0] hi);
      if (v < signed'({26'h0000000, lo})) begin
         return lo;
      end
      if (v > signed'({26'h0000000, hi})) begin
         return hi;
      end
      return v[7:0];
   endfunction : clamp8

   // The table is a constant and folds into a small ROM.
   // A quarter wave would be enough, but a full period keeps the
   // three phase lookups free of any sign or mirror handling.
   localparam msvg_rom_t SINE_ROM = build_rom();

   msvg_state_t st_reg;   // Registered state.
   msvg_state_t st_next;  // Next state.

   // All outputs come straight from the state register.
   // No output depends on the bus inputs in the same cycle, so there is
   // no combinational path from the master back to itself.
   assign prdata    = st_reg.prdata;
   assign pready    = st_reg.pready;
   assign pslverr   = st_reg.pslverr;
   assign gate_high = st_reg.hs;
   assign gate_low  = st_reg.ls;
   assign meas_trig = st_reg.mtrig;
   assign dir_trig  = st_reg.dtrig;
   assign tb_tick   = st_reg.tick;
   assign amplitude = st_reg.amp;

   // Update order in this process matters: hardware updates first,
   // register writes after them so software wins a collision, and the
   // disable branch last. The disable branch leaves software owned
   // registers alone, so a set-up written while idle survives enable.
   // Next state: bus, time base, PID, ramp, prescaler adjust and PWM.
   always_comb begin
      logic [7:0]         ix;       // Register index of the access.
      logic               known;    // Index is mapped.
      logic               wr;       // Write takes effect this edge.
      logic [31:0]        rd;       // Read mux.
      logic [16:0]        step;     // Accumulator step.
      logic [17:0]        sum_acc;  // Accumulator plus step.
      logic               adv;      // Divider lets the mantissa advance.
      logic               tk;       // Overflow this cycle.
      int                 pv;       // Prescaler value.
      logic signed [23:0] err;      // Turn length error.
      logic signed [23:0] derr;     // Error change.
      logic signed [31:0] nsum;     // New error sum.
      logic signed [33:0] cv;       // Control value.
      logic [7:0]         a3 [3];   // Phase addresses.
      logic [8:0]         thr;      // High side threshold.
      logic [9:0]         lth;      // Low side threshold.
      logic [8:0]         cn;       // Next carrier.
      st_next = st_reg;
      ix      = paddr[9:2];
      wr      = 1'b0;
      rd      = 32'h00000000;
      known   = 1'b1;
      step    = 17'h00000;
      sum_acc = 18'h00000;
      adv     = 1'b0;
      tk      = 1'b0;
      pv      = sm_to_int(st_reg.presc);
      err     = 24'sh000000;
      derr    = 24'sh000000;
      nsum    = 32'sh00000000;
      cv      = 34'sh000000000;
      a3[0]   = 8'h00;
      a3[1]   = 8'h00;
      a3[2]   = 8'h00;
      thr     = 9'h000;
      lth     = 10'h000;
      cn      = 9'h000;

      // Read mux; narrow registers sit in the low bits.
      unique case (ix)
         `MSVG_IX_PRESC:    rd = {27'h0000000, st_reg.presc};
         `MSVG_IX_PER_H:    rd = {25'h0000000, st_reg.cntmax[14:8]};
         `MSVG_IX_PER_L:    rd = {24'h000000, st_reg.cntmax[7:0]};
         `MSVG_IX_SCALE:    rd = {24'h000000, st_reg.scale};
         `MSVG_IX_CEIL:     rd = {24'h000000, st_reg.ceil};
         `MSVG_IX_KP:       rd = {28'h0000000, st_reg.kp};
         `MSVG_IX_KI:       rd = {28'h0000000, st_reg.ki};
         `MSVG_IX_KD:       rd = {28'h0000000, st_reg.kd};
         `MSVG_IX_CTRL:     rd = {28'h0000000, st_reg.ctrl};
         `MSVG_IX_MIN:      rd = {24'h000000, st_reg.minlim};
         `MSVG_IX_DEAD:     rd = {24'h000000, st_reg.dead};
         `MSVG_IX_TGT_H:    rd = {24'h000000, st_reg.target[15:8]};
         `MSVG_IX_TGT_L:    rd = {24'h000000, st_reg.target[7:0]};
         `MSVG_IX_RAMP_NUM: rd = {24'h000000, st_reg.rampnum};
         `MSVG_IX_SLOPE:    rd = {28'h0000000, st_reg.slope};
         `MSVG_IX_AMP:      rd = {24'h000000, st_reg.amp};
         `MSVG_IX_ANGLE:    rd = {24'h000000, st_reg.angle};
         default:           known = 1'b0;
      endcase

      // APB: no wait state, answer in the first access cycle.
      // Read data is latched in the setup cycle, so a moving counter
      // still reads as one coherent value.
      st_next.pready  = psel & ~penable & ~st_reg.pready;
      st_next.pslverr = psel & ~penable & ~st_reg.pready & ~known;
      if (psel & ~penable) begin
         st_next.prdata = pwrite ? 32'h00000000 : rd;
      end
      wr = psel & penable & st_reg.pready & pwrite & known & pstrb[0];

      // Time base: mantissa advances 2^(1-p) per cycle for p below one, else
      // once every 2^(p-1) cycles; one overflow at most per cycle.
      // A step larger than the mantissa saturates the tick rate at the
      // clock rate instead of wrapping to a slower rate.
      // tick rate
      if (pv >= 1) begin
         adv = (st_reg.precnt >= 16'((1 << (pv - 1)) - 1));
         st_next.precnt = adv ? 16'h0000 : st_reg.precnt + 16'h0001;
         step = 17'h00001;
      end else begin
         adv  = 1'b1;
         step = 17'(1 << (1 - pv));
      end
      if (block_en && adv && st_reg.cntmax != 15'h0000) begin
         sum_acc = {1'b0, st_reg.acc} + {1'b0, step};
         if (sum_acc >= {3'b000, st_reg.cntmax}) begin
            tk = 1'b1;
            sum_acc = sum_acc - {3'b000, st_reg.cntmax};
            // Steps far above the mantissa would pile up; drop the excess.
            st_next.acc = (sum_acc >= {3'b000, st_reg.cntmax}) ? 17'h00000 : sum_acc[16:0];
         end else begin
            st_next.acc = sum_acc[16:0];
         end
      end
      st_next.tick = tk;

      if (tk) begin
         st_next.angle = st_reg.angle + 8'h01;
      end

      // The turn counter saturates at 24'hFFFFFF, which the signed error reads as -1,
      // so a stalled time base gives a negative error of -1 minus the target.
      // turn length error
      st_next.turncnt = (st_reg.turncnt == 24'hFFFFFF) ? st_reg.turncnt
                        : st_reg.turncnt + 24'h000001;
      err  = signed'(st_reg.turncnt) - signed'({8'h00, st_reg.target});
      derr = err - st_reg.elast;
      nsum = st_reg.esum + 32'(err);
      // A turn ends when the address wraps, i.e. every 256 ticks.
      // turn is 256 ticks
      if (tk && st_reg.angle == 8'hFF) begin
         st_next.turncnt = 24'h000001;
         if (st_reg.ctrl[`MSVG_CTRL_SPD]) begin
            // Gains are powers of two, so each term is an arithmetic shift;
            // negative terms round toward minus infinity.
            // PID update
            st_next.esum  = nsum;
            st_next.elast = err;
            cv = 34'(nsum >>> st_reg.ki) + 34'(err >>> st_reg.kp)
                 + 34'(derr >>> st_reg.kd);
            if (st_reg.ctrl[`MSVG_CTRL_AMP]) begin
               st_next.amp = clamp8(cv, st_reg.minlim, st_reg.ceil);
            end else begin
               st_next.scale = clamp8(cv, st_reg.minlim, 8'hFF);
            end
         end
      end

      // Ramp: shrink the mantissa by its 2^-slope share every rampnum ticks.
      // A slope of zero clears the mantissa and stops the time base, so
      // software must not enable the ramp with it.
      if (tk && st_reg.ctrl[`MSVG_CTRL_RAMP]) begin
         st_next.rampcnt = st_reg.rampcnt + 8'h01;
         if (st_next.rampcnt >= st_reg.rampnum) begin
            st_next.rampcnt = 8'h00;
            st_next.cntmax  = st_reg.cntmax - (st_reg.cntmax >> st_reg.slope);
         end
      end

      // Prescaler adjust: renormalise so the mantissa reads 01xx..x.
      // It works on the mantissa after the ramp step of the same tick,
      // so both units may act on one tick and neither update is lost.
      // keep bits 01
      if (tk && st_reg.ctrl[`MSVG_CTRL_AUTO]) begin
         if (st_next.cntmax[14] && pv < `MSVG_PRESC_LIM) begin
            st_next.cntmax = st_next.cntmax >> 1;
            st_next.presc  = int_to_sm(pv + 1);
         end else if (!st_next.cntmax[13] && st_next.cntmax != 15'h0000
                      && pv > -`MSVG_PRESC_LIM) begin
            st_next.cntmax = st_next.cntmax << 1;
            st_next.presc  = int_to_sm(pv - 1);
         end
      end

      // Gates are compared against the next carrier value, so the
      // registered gates line up with the registered carrier.
      // one step per clock
      if (st_reg.up) begin
         cn = st_reg.carrier + 9'h001;
         st_next.up = (cn != `MSVG_PWM_MAX);
      end else begin
         cn = st_reg.carrier - 9'h001;
         st_next.up = (cn == 9'h000);
      end
      st_next.carrier = cn;

      // 0x55 and 0xAB are the nearest table steps to one and two thirds
      // of a turn; the split is 85, 86 and 85 steps.
      // 120 degree offsets
      a3[0] = st_reg.angle;
      a3[1] = st_reg.angle + 8'h55;
      a3[2] = st_reg.angle + 8'hAB;
      for (int k = 0; k < 3; k++) begin
         thr = phase_thr(SINE_ROM[a3[k]], st_reg.scale);
         st_next.hs[k] = (cn < thr);
         lth = {1'b0, thr} + {2'b00, st_reg.dead};
         st_next.ls[k] = (lth < {1'b0, `MSVG_PWM_MAX}) && ({1'b0, cn} >= lth);
         st_next.mtrig[k] = st_reg.up && (cn == 9'(k + 1));
      end
      // The peak marks the point where every high side gate is off.
      st_next.dtrig = (cn == `MSVG_PWM_MAX);

      // Register writes; they win over hardware updates in the same cycle.
      // Only the lowest byte lane is used; every register is one byte.
      if (wr) begin
         unique case (ix)
            `MSVG_IX_PRESC:    st_next.presc = pwdata[4:0];
            `MSVG_IX_PER_H:    st_next.cntmax[14:8] = pwdata[6:0];
            `MSVG_IX_PER_L:    st_next.cntmax[7:0] = pwdata[7:0];
            `MSVG_IX_SCALE:    st_next.scale = pwdata[7:0];
            `MSVG_IX_CEIL:     st_next.ceil = pwdata[7:0];
            `MSVG_IX_KP:       st_next.kp = pwdata[3:0];
            `MSVG_IX_KI:       st_next.ki = pwdata[3:0];
            `MSVG_IX_KD:       st_next.kd = pwdata[3:0];
            `MSVG_IX_CTRL:     st_next.ctrl = pwdata[3:0];
            `MSVG_IX_MIN:      st_next.minlim = pwdata[7:0];
            `MSVG_IX_DEAD:     st_next.dead = pwdata[7:0];
            `MSVG_IX_TGT_H:    st_next.target[15:8] = pwdata[7:0];
            `MSVG_IX_TGT_L:    st_next.target[7:0] = pwdata[7:0];
            `MSVG_IX_RAMP_NUM: st_next.rampnum = pwdata[7:0];
            `MSVG_IX_SLOPE:    st_next.slope = pwdata[3:0];
            default:           st_next.amp = st_reg.amp;
         endcase
      end

      // Disabled: gates low, counters and controller history cleared.
      // Clearing the error sum avoids a kick from stale history when
      // the speed loop starts again.
      // hold inactive
      if (!block_en) begin
         st_next.carrier = 9'h000;
         st_next.up      = 1'b1;
         st_next.hs      = 3'b000;
         st_next.ls      = 3'b000;
         st_next.mtrig   = 3'b000;
         st_next.dtrig   = 1'b0;
         st_next.precnt  = 16'h0000;
         st_next.acc     = 17'h00000;
         st_next.angle   = 8'h00;
         st_next.turncnt = 24'h000000;
         st_next.rampcnt = 8'h00;
         st_next.esum    = 32'sh00000000;
         st_next.elast   = 24'sh000000;
      end
   end

   // State register, synchronous active low reset.
   // The carrier resets to counting up, so the first PWM cycle after
   // reset starts from zero like every later one.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_reg    <= '0;
         st_reg.up <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

endmodule : msvg_top

//--- verif/msvg_bridge_model.sv
// Purpose: Gate driver and half bridge model for the three phases.
// Assumes: Gate controls are active high.
// Notes:   A phase with both switches off floats and toggles.
`timescale 1ns/1ns
module msvg_bridge_model (
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire logic [2:0] gate_high,
   input wire logic [2:0] gate_low,
   output logic [2:0]     phase_out,
   output logic           shoot_thru
);
   // Both switches on would short the supply, so it is latched.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         phase_out  <= 3'h0;
         shoot_thru <= 1'b0;
      end else begin
         shoot_thru <= shoot_thru | (|(gate_high & gate_low));
         // A floating node never shows a steady stale level.
         phase_out  <= (gate_high | (~gate_low & ~phase_out)) & ~gate_low;
      end
   end
endmodule : msvg_bridge_model

//--- verif/msvg_chk.sv
// Purpose: Port checker for the phase voltage generator.
// Assumes: One clock; reset_n is synchronous and active low.
// Notes:   Bound to msvg_top at the foot of this file.
`timescale 1ns/1ns
module msvg_chk
   import msvg_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        block_en,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [2:0]  gate_high,
   input wire logic [2:0]  gate_low,
   input wire logic [2:0]  meas_trig,
   input wire logic        dir_trig,
   input wire logic        tb_tick
);
   localparam int MEAS_LAG = 355; // Carrier steps from 3 up to the peak.
   logic [9:0] gap_reg;           // Cycles since the last peak pulse.
   logic       seen_reg;          // A peak pulse was seen since enable.
   // Gap counter; cleared while idle so a restart is not judged.
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !block_en) begin
         gap_reg  <= 10'h000;
         seen_reg <= 1'b0;
      end else begin
         gap_reg  <= dir_trig ? 10'h000 : gap_reg + 10'h001;
         seen_reg <= seen_reg | dir_trig;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Bus setup cycle and the trigger burst after the carrier floor.
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_burst;
      meas_trig == 3'h2 ##1 meas_trig == 3'h4 ##[MEAS_LAG:MEAS_LAG] dir_trig;
   endsequence
   AST_READY_SETUP: assert property (s_setup |=> pready)
      else $error("ready missing after setup");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_ERR_READY: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_RD_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   AST_NO_OVERLAP: assert property ((gate_high & gate_low) == 3'h0)
      else $error("high and low gate on together");
   AST_IDLE: assert property (!block_en |=> gate_high == 3'h0 && gate_low == 3'h0
      && meas_trig == 3'h0 && !dir_trig && !tb_tick)
      else $error("outputs active while idle");
   AST_PWM_PERIOD: assert property (disable iff (!reset_n || !block_en)
      dir_trig && seen_reg |-> gap_reg == 10'h2CB)
      else $error("carrier period wrong");
   AST_MEAS_ORDER: assert property (disable iff (!reset_n || !block_en)
      meas_trig == 3'h1 |=> s_burst)
      else $error("trigger order wrong");
endmodule : msvg_chk
bind msvg_top msvg_chk i_msvg_chk (.clk_sys(clk_sys), .reset_n(reset_n),
   .block_en(block_en), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .gate_high(gate_high),
   .gate_low(gate_low), .meas_trig(meas_trig), .dir_trig(dir_trig), .tb_tick(tb_tick));

//--- verif/msvg_top_tb_top.sv
// Purpose: Register, PWM, time base, ramp and speed control tests.
// Assumes: 10 MHz clock; APB with one access cycle.
// Notes:   Gate counts are taken on the falling edge.
`timescale 1ns/1ns
module msvg_top_tb_top
   import msvg_pkg::*;
;
`include "msvg_defs.svh"
   logic        clk_sys, reset_n, block_en, psel, penable, pwrite;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [3:0]  pstrb;
   logic        pready, pslverr, dir_trig, tb_tick, shoot_thru, erv;
   logic [2:0]  gate_high, gate_low, meas_trig, phase_out;
   logic [7:0]  amplitude;
   int          error_cnt, num_checks, cyc, n_meas, n_dir, n_tick;
   int          n_hi[3], n_lo[3];
   logic [7:0]  ix_tab[8] = '{`MSVG_IX_PRESC, `MSVG_IX_PER_H, `MSVG_IX_PER_L,
      `MSVG_IX_SCALE, `MSVG_IX_CEIL, `MSVG_IX_KP, `MSVG_IX_KI, `MSVG_IX_KD};
   logic [7:0]  mk_tab[8] = '{8'h1F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h0F};
   msvg_top i_msvg_top (.clk_sys(clk_sys), .reset_n(reset_n), .block_en(block_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .gate_high(gate_high), .gate_low(gate_low), .meas_trig(meas_trig),
      .dir_trig(dir_trig), .tb_tick(tb_tick), .amplitude(amplitude));
   msvg_bridge_model i_msvg_bridge_model (.clk_sys(clk_sys), .reset_n(reset_n),
      .gate_high(gate_high), .gate_low(gate_low), .phase_out(phase_out),
      .shoot_thru(shoot_thru));
   // Free running clock, 100 ns period.
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Counts on the falling edge avoid racing the main sequence.
   always @(negedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         end_sim();
      end
      for (int k = 0; k < 3; k++) begin
         n_hi[k] += gate_high[k];
         n_lo[k] += gate_low[k];
         n_meas  += meas_trig[k];
      end
      n_dir  += dir_trig;
      n_tick += tb_tick;
   end
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; held until ready is sampled high.
   task apb(input logic w, input logic [7:0] ix, input logic [7:0] d, input logic st);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {ix, 2'h0};
      pwdata  <= {24'h000000, d};
      pstrb   <= {3'h0, st};
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rdv = prdata;
      erv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] ix, input logic [7:0] d);
      apb(1'b1, ix, d, 1'b1);
   endtask : wr
   task rd(input logic [7:0] ix, input logic [7:0] e);
      apb(1'b0, ix, 8'h00, 1'b1);
      chk(rdv, {24'h000000, e});
   endtask : rd
   task win(input int n);
      // Let the last write settle for 20 cycles first.
      repeat (20) @(posedge clk_sys);
      n_hi = '{0, 0, 0};
      n_lo = '{0, 0, 0};
      {n_meas, n_dir, n_tick} = '0;
      repeat (n) @(posedge clk_sys);
   endtask : win
   // Main sequence.
   initial begin
      {reset_n, block_en, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {error_cnt, num_checks, cyc} = '0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      foreach (ix_tab[i]) rd(ix_tab[i], `MSVG_RST_BYTE);
      foreach (ix_tab[i]) begin
         wr(ix_tab[i], 8'hFF);
         rd(ix_tab[i], mk_tab[i]);
      end
      apb(1'b1, 8'h00, 8'h5A, 1'b1);
      chk({31'h0, erv}, 32'h1);
      apb(1'b1, `MSVG_IX_MIN, 8'h77, 1'b0);
      rd(`MSVG_IX_MIN, 8'h00);
      $display("test registers done");
      wr(`MSVG_IX_SCALE, 8'h00);
      block_en <= 1'b1;
      foreach (mk_tab[i]) if (i < 3) begin
         wr(`MSVG_IX_DEAD, i == 0 ? 8'h10 : 8'hB1 + 8'(i));
         win(716);
         for (int k = 0; k < 3; k++) begin
            chk(n_hi[k], 357);
            chk(n_lo[k], i == 0 ? 327 : (i == 1 ? 3 : 0));
         end
         chk(n_meas, 3);
         chk(n_dir, 1);
      end
      chk({31'h0, shoot_thru}, 32'h0);
      $display("test pwm done");
      wr(`MSVG_IX_PER_H, 8'h00);
      wr(`MSVG_IX_PER_L, 8'h08);
      foreach (mk_tab[i]) if (i < 4) begin
         wr(`MSVG_IX_PRESC, i == 3 ? 8'h11 : (i == 2 ? 8'h00 : 8'(i + 1)));
         win(400);
         chk(n_tick, i == 0 ? 50 : (i == 1 ? 25 : (i == 2 ? 100 : 200)));
      end
      $display("test time base done");
      block_en <= 1'b0;
      wr(`MSVG_IX_PER_H, 8'h01);
      wr(`MSVG_IX_PER_L, 8'h00);
      wr(`MSVG_IX_PRESC, 8'h01);
      wr(`MSVG_IX_RAMP_NUM, 8'h02);
      wr(`MSVG_IX_SLOPE, 8'h02);
      wr(`MSVG_IX_CTRL, 8'h04);
      block_en <= 1'b1;
      repeat (2) begin
         @(posedge clk_sys);
         while (tb_tick !== 1'b1) @(posedge clk_sys);
      end
      repeat (20) @(posedge clk_sys);
      wr(`MSVG_IX_CTRL, 8'h00);
      rd(`MSVG_IX_PER_L, 8'hC0);
      rd(`MSVG_IX_PER_H, 8'h00);
      $display("test ramp done");
      block_en <= 1'b0;
      wr(`MSVG_IX_PER_H, 8'h08);
      wr(`MSVG_IX_PRESC, 8'h01);
      wr(`MSVG_IX_CTRL, 8'h08);
      block_en <= 1'b1;
      repeat (5000) @(posedge clk_sys);
      rd(`MSVG_IX_PRESC, 8'h11);
      rd(`MSVG_IX_PER_H, 8'h23);
      $display("test prescaler adjust done");
      block_en <= 1'b0;
      wr(`MSVG_IX_PER_H, 8'h00);
      wr(`MSVG_IX_PER_L, 8'h04);
      wr(`MSVG_IX_PRESC, 8'h01);
      wr(`MSVG_IX_MIN, 8'h10);
      wr(`MSVG_IX_CEIL, 8'h40);
      wr(`MSVG_IX_KP, 8'h00);
      wr(`MSVG_IX_TGT_H, 8'h01);
      wr(`MSVG_IX_TGT_L, 8'h00);
      wr(`MSVG_IX_CTRL, 8'h01);
      block_en <= 1'b1;
      repeat (7000) @(posedge clk_sys);
      rd(`MSVG_IX_SCALE, 8'hFF);
      wr(`MSVG_IX_TGT_H, 8'hFF);
      wr(`MSVG_IX_TGT_L, 8'hFF);
      repeat (7000) @(posedge clk_sys);
      rd(`MSVG_IX_SCALE, 8'h10);
      wr(`MSVG_IX_CTRL, 8'h03);
      repeat (7000) @(posedge clk_sys);
      chk({24'h000000, amplitude}, 32'h10);
      wr(`MSVG_IX_TGT_H, 8'h01);
      wr(`MSVG_IX_TGT_L, 8'h00);
      repeat (7000) @(posedge clk_sys);
      chk({24'h000000, amplitude}, 32'h40);
      $display("test speed control done");
      end_sim();
   end
endmodule : msvg_top_tb_top
